// *** verilog/lem_params.svh ***
// constants of the line event monitor: offsets, field positions, resets, counts
// assumes inclusion by bare name from the design files
`ifndef LEM_PARAMS_SVH
`define LEM_PARAMS_SVH
`define LEM_ADDR_STATUS 5'h05
`define LEM_ADDR_MODE 5'h09
`define LEM_ADDR_EVENT_ENABLE_MASK 5'h0a
`define LEM_ADDR_DIPLVL 5'h0b
`define LEM_ADDR_DIPCYC 5'h0c
`define LEM_ADDR_TEMP 5'h0d
`define LEM_ADDR_CROSSING_TIMEOUT_RELOAD 5'h0e
`define LEM_MODE_DIPDIS 4
`define LEM_MODE_TEMPGO 5
`define LEM_FLAG_DIP 3
`define LEM_FLAG_TEMP 5
`define LEM_RST_CROSSING_TIMEOUT_RELOAD 16'hffff
`define LEM_RST_MODE 8'h00
`define LEM_RST_EVENT_ENABLE_MASK 8'h00
`define LEM_RST_DIPLVL 8'h00
`define LEM_RST_DIPCYC 8'h00
`define LEM_TOUT_PRESCALE 64
`define LEM_TEMP_CYCLES 24
`define LEM_LPF_SHIFT 5
`endif

// *** verilog/lem_pkg.sv ***
// types shared by the line event monitor
// assumes nothing beyond a SystemVerilog compiler
package lem_pkg;
  typedef struct packed {
    logic write;
    logic [1:0] spare;
    logic [4:0] addr;
  } lem_cmd_type;
  typedef struct packed {
    logic valid;
    logic [19:0] data;
  } lem_sample_type;
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } lem_serial_type;
  typedef enum logic [1:0] {LEM_IDLE, LEM_CMD, LEM_DATA} lem_phase_type;
endpackage

// *** verilog/lem_monitor.sv ***
// line event monitor: zero crossing, crossing timeout, dip detection,
// clear-on-read event flags, crossing-triggered temperature capture
// assumes channel-2 samples and the temperature code arrive on clk
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`default_nettype none
`include "lem_params.svh"
module lem_monitor #(
  parameter int LPF_SHIFT = `LEM_LPF_SHIFT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial port pins
  input wire lem_pkg::lem_serial_type serial_in,
  output logic dout,
  output logic dout_oe_n,
  // channel 2 and temperature sensor path
  input wire lem_pkg::lem_sample_type ch2_sample,
  input wire logic [7:0] temp_code,
  output logic temp_route,
  // event outputs
  output logic zero_cross_out,
  output logic voltage_dip_out_n,
  output logic irq_n
);
  import lem_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  logic [2:0] sync1, sync2, sync3, pin_f, pin_d;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        sync1[gi] <= serial_in[gi];
        sync2[gi] <= sync1[gi];
        sync3[gi] <= sync2[gi];
        if (rst) begin
          // idle levels: serial clock and select high, so no false edge follows reset
          pin_f[gi] <= (gi != 0);
          pin_d[gi] <= (gi != 0);
        end else begin
          if (sync2[gi] == sync3[gi]) begin
            pin_f[gi] <= sync3[gi];
          end
          pin_d[gi] <= pin_f[gi];
        end
      end
    end
  endgenerate
  wire logic sclk_fall = pin_d[2] & ~pin_f[2];
  wire logic sclk_rise = ~pin_d[2] & pin_f[2];
  wire logic cs_act = ~pin_f[1];
  wire logic din_f = pin_f[0];
  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] status, mode, event_enable_mask, dip_lvl, dip_cyc, thermal_result;
  logic [15:0] tout_reload, tout_cnt;
  logic wr_stb, rd_clr, irq_hold;
  logic [4:0] wr_addr;
  logic [15:0] wr_data;
  logic [7:0] events;
  logic temp_done;
  //////////////////////////////////////////////////////////////////////////////
  // channel 2 low-pass and crossing detect
  logic signed [19:0] lpf;
  logic zc_det, zc_pos;
  always_ff @(posedge clk) begin
    if (rst) begin
      lpf <= '0;
    end else if (ch2_sample.valid) begin
      lpf <= lpf + (($signed(ch2_sample.data) - lpf) >>> LPF_SHIFT);
    end
  end
  logic prev_sign;
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_sign <= 1'b0;
      zc_det <= 1'b0;
      zc_pos <= 1'b0;
      zero_cross_out <= 1'b0;
    end else begin
      prev_sign <= lpf[19];
      zc_det <= prev_sign != lpf[19];
      zc_pos <= prev_sign & ~lpf[19];
      if (prev_sign != lpf[19]) begin
        zero_cross_out <= ~lpf[19];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // crossing timeout
  logic [5:0] presc;
  logic tout_event, tout_exp;
  always_ff @(posedge clk) begin
    if (rst) begin
      presc <= '0;
      tout_cnt <= `LEM_RST_CROSSING_TIMEOUT_RELOAD;
      tout_event <= 1'b0;
      tout_exp <= 1'b0;
    end else begin
      presc <= presc + 6'h01;
      tout_event <= 1'b0;
      if (zc_det) begin
        tout_cnt <= tout_reload;
        tout_exp <= 1'b0;
      end else if (presc == 6'(`LEM_TOUT_PRESCALE - 1) && tout_cnt != 16'h0000) begin
        tout_cnt <= tout_cnt - 16'h0001;
        if (tout_cnt == 16'h0001) begin
          tout_event <= 1'b1;
          tout_exp <= 1'b1;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // level dip detection
  logic [19:0] abs_lpf;
  logic [7:0] lvl_byte, dip_cnt;
  logic above, level_dip, dip_event;
  logic hc_above;
  assign abs_lpf = lpf[19] ? 20'(-lpf) : lpf;
  assign lvl_byte = abs_lpf[18:11];
  assign above = lvl_byte > dip_lvl;
  always_ff @(posedge clk) begin
    if (rst) begin
      dip_cnt <= '0;
      level_dip <= 1'b0;
      dip_event <= 1'b0;
      hc_above <= 1'b0;
    end else begin
      dip_event <= 1'b0;
      if (above) begin
        dip_cnt <= '0;
        hc_above <= 1'b1;
        level_dip <= 1'b0;
      end else if (zc_det) begin
        // a half cycle that was above at any point does not count
        hc_above <= 1'b0;
        if (!hc_above && dip_cnt != 8'hff) begin
          dip_cnt <= dip_cnt + 8'h01;
          if (dip_cnt + 8'h01 == dip_cyc && !level_dip) begin
            level_dip <= 1'b1;
            dip_event <= 1'b1;
          end
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      voltage_dip_out_n <= 1'b0;
    end else begin
      voltage_dip_out_n <= !((level_dip | tout_exp) & !mode[`LEM_MODE_DIPDIS]);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // temperature conversion
  logic temp_busy;
  logic [4:0] temp_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_busy <= 1'b0;
      temp_cnt <= '0;
      temp_done <= 1'b0;
      temp_route <= 1'b0;
      thermal_result <= '0;
    end else begin
      temp_done <= 1'b0;
      if (!temp_busy && zc_det && mode[`LEM_MODE_TEMPGO]) begin
        temp_busy <= 1'b1;
        temp_route <= 1'b1;
        temp_cnt <= 5'(`LEM_TEMP_CYCLES - 1);
      end else if (temp_busy) begin
        temp_cnt <= temp_cnt - 5'h01;
        if (temp_cnt == 5'h00) begin
          temp_busy <= 1'b0;
          temp_route <= 1'b0;
          temp_done <= 1'b1;
          thermal_result <= temp_code;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // host-written registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= `LEM_RST_MODE;
      event_enable_mask <= `LEM_RST_EVENT_ENABLE_MASK;
      dip_lvl <= `LEM_RST_DIPLVL;
      dip_cyc <= `LEM_RST_DIPCYC;
      tout_reload <= `LEM_RST_CROSSING_TIMEOUT_RELOAD;
    end else begin
      if (temp_done) begin
        mode[`LEM_MODE_TEMPGO] <= 1'b0;
      end
      if (wr_stb) begin
        case (wr_addr)
          `LEM_ADDR_MODE: mode <= wr_data[7:0];
          `LEM_ADDR_EVENT_ENABLE_MASK: event_enable_mask <= wr_data[7:0];
          `LEM_ADDR_DIPLVL: dip_lvl <= wr_data[7:0];
          `LEM_ADDR_DIPCYC: dip_cyc <= wr_data[7:0];
          `LEM_ADDR_CROSSING_TIMEOUT_RELOAD: tout_reload <= wr_data;
          default: ;
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // event flags and request line
  always_comb begin
    events = 8'h00;
    events[`LEM_FLAG_DIP] = tout_event | dip_event;
    events[`LEM_FLAG_TEMP] = temp_done;
  end
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_ff @(posedge clk) begin
        if (rst) begin
          status[gi] <= 1'b0;
        end else if (events[gi]) begin
          status[gi] <= 1'b1;
        end else if (rd_clr) begin
          status[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !((|(status & event_enable_mask)) && !irq_hold);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // serial port
  function automatic logic [15:0] read_value(input logic [4:0] a);
    case (a)
      `LEM_ADDR_STATUS: read_value = {status, 8'h00};
      `LEM_ADDR_MODE: read_value = {mode, 8'h00};
      `LEM_ADDR_EVENT_ENABLE_MASK: read_value = {event_enable_mask, 8'h00};
      `LEM_ADDR_DIPLVL: read_value = {dip_lvl, 8'h00};
      `LEM_ADDR_DIPCYC: read_value = {dip_cyc, 8'h00};
      `LEM_ADDR_TEMP: read_value = {thermal_result, 8'h00};
      `LEM_ADDR_CROSSING_TIMEOUT_RELOAD: read_value = tout_reload;
      default: read_value = 16'h0000;
    endcase
  endfunction
  lem_phase_type phase;
  lem_cmd_type cmd, next_cmd;
  logic [4:0] bitcnt, last_bit;
  logic [15:0] rx, tx;
  assign next_cmd = {cmd[6:0], din_f};
  assign last_bit = (cmd.addr == `LEM_ADDR_CROSSING_TIMEOUT_RELOAD) ? 5'h17 : 5'h0f;
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= LEM_IDLE;
      cmd <= '0;
      bitcnt <= '0;
      rx <= '0;
      tx <= '0;
      wr_stb <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      rd_clr <= 1'b0;
      irq_hold <= 1'b0;
      dout <= 1'b0;
      dout_oe_n <= 1'b1;
    end else begin
      wr_stb <= 1'b0;
      rd_clr <= 1'b0;
      if (!cs_act) begin
        phase <= LEM_IDLE;
        bitcnt <= '0;
        irq_hold <= 1'b0;
        dout_oe_n <= 1'b1;
      end else if (sclk_fall) begin
        bitcnt <= bitcnt + 5'h01;
        if (phase != LEM_DATA) begin
          phase <= LEM_CMD;
          cmd <= next_cmd;
          if (bitcnt == 5'h07) begin
            phase <= LEM_DATA;
            tx <= read_value(next_cmd.addr);
            if (!next_cmd.write && next_cmd.addr == `LEM_ADDR_STATUS) begin
              rd_clr <= 1'b1;
              irq_hold <= 1'b1;
            end
          end
        end else begin
          rx <= {rx[14:0], din_f};
          if (bitcnt == last_bit) begin
            phase <= LEM_IDLE;
            irq_hold <= 1'b0;
            if (cmd.write) begin
              wr_stb <= 1'b1;
              wr_addr <= cmd.addr;
              wr_data <= {rx[14:0], din_f};
            end
          end
        end
      end else if (sclk_rise && phase == LEM_DATA && !cmd.write) begin
        dout <= tx[15];
        tx <= {tx[14:0], 1'b0};
        dout_oe_n <= 1'b0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_ZX_HIGH: assert property (zc_pos |=> zero_cross_out)
    else $error("zero cross output not high after rising crossing");
  AST_TOUT_RELOAD: assert property (zc_det |=> tout_cnt == $past(tout_reload))
    else $error("timeout counter not reloaded on crossing");
  AST_TOUT_HOLD: assert property ((tout_cnt == 16'h0000 && !zc_det) |=> tout_cnt == 16'h0000)
    else $error("expired timeout counter moved without crossing");
  AST_TOUT_FLAG: assert property (tout_event |=> status[`LEM_FLAG_DIP])
    else $error("timeout expiry did not set dip flag");
  AST_DIP_PIN: assert property ((tout_exp && !mode[`LEM_MODE_DIPDIS]) |=> !voltage_dip_out_n)
    else $error("dip pin not low after timeout expiry");
  AST_IRQ_ON: assert property (((|(status & event_enable_mask)) && !irq_hold) |=> !irq_n)
    else $error("request line not asserted for enabled flag");
  AST_IRQ_HOLD: assert property (rd_clr |=> irq_hold && irq_n)
    else $error("request not released during status read");
  AST_STATUS_CLR: assert property ((rd_clr && events == 8'h00) |=> status == 8'h00)
    else $error("status not cleared by read");
  AST_EVENT_KEPT: assert property ((rd_clr && temp_done) |=> status[`LEM_FLAG_TEMP])
    else $error("event lost during status read");
  AST_TEMP_TIME: assert property ((!temp_busy && zc_det && mode[`LEM_MODE_TEMPGO])
    |=> temp_busy [*8] ##17 temp_done)
    else $error("temperature result not stored 24 cycles after crossing");
  AST_RST_DIP: assert property (@(posedge clk) disable iff (1'b0) rst |=> !voltage_dip_out_n)
    else $error("dip pin not low after reset");
  AST_ZX_LOW: assert property ((zc_det && !zc_pos) |=> !zero_cross_out)
    else $error("zero cross output not low after falling crossing");
  AST_DIP_RELEASE: assert property (above |=> !level_dip)
    else $error("level dip not released above threshold");
  AST_LEVEL_FLAG: assert property (dip_event |=> status[`LEM_FLAG_DIP])
    else $error("level dip did not set dip flag");
  AST_TEMP_CLEAR: assert property ((temp_done && !wr_stb) |=> !mode[`LEM_MODE_TEMPGO])
    else $error("temperature start bit not cleared after result");
endmodule // lem_monitor
`default_nettype wire

// *** testbench/lem_host.sv ***
// host model: serial master that frames commands and data for the monitor
// assumes the monitor's serial pin struct; serial clock period 400 ns, idle high
`timescale 1ns/1ns
`default_nettype none
module lem_host (
  // serial pins
  output var lem_pkg::lem_serial_type ser,
  input wire logic dout,
  input wire logic dout_oe_n,
  // request line, sampled mid-frame
  input wire logic irq_n
);
  import lem_pkg::*;
  logic irq_mid;
  initial begin
    ser = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
  end
  // command byte then nb data bits, msb first; a bit is read just before the next rise
  task automatic xfer(input logic [7:0] cmd, input int nb, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd << (16 - nb)};
    rd = '0;
    irq_mid = 1'bx;
    #50 ser.cs_n = 1'b0;
    for (int i = 0; i < 8 + nb; i++) begin
      ser.din = sh[23 - i];
      #200 ser.sclk = 1'b0;
      #190;
      if (i >= 8) begin
        rd = {rd[14:0], dout_oe_n ? 1'bx : dout};
      end
      if (i == 9) begin
        irq_mid = irq_n;
      end
      #10 ser.sclk = 1'b1;
    end
    #200 ser.cs_n = 1'b1;
    // released data line does not keep its last level
    ser.din = ~ser.din;
    #200;
  endtask
endmodule // lem_host
`default_nettype wire

// *** testbench/tb_top.sv ***
// bench: serial host model plus channel-2 stimulus; an integer model of filter,
// crossing and dip logic is compared at every sample and register read
// assumes lem_pkg, lem_monitor and lem_host compiled first
`timescale 1ns/1ns
`default_nettype none
`include "lem_params.svh"
module tb_top;
  import lem_pkg::*;
  logic clk, rst, dout, dout_oe_n, temp_route, zc, dip_n, irq_n, z0;
  lem_serial_type ser;
  lem_sample_type smp;
  logic [7:0] tcode, flags, en;
  logic [15:0] rd;
  logic [31:0] lfsr;
  int n_mismatch, comparisons, k, amp, x, y, lvl, half, run, thr, cyc, cnt, above, dip, zce;
  lem_monitor lem_monitor_i (.clk(clk), .rst(rst), .serial_in(ser), .dout(dout),
    .dout_oe_n(dout_oe_n), .ch2_sample(smp), .temp_code(tcode), .temp_route(temp_route),
    .zero_cross_out(zc), .voltage_dip_out_n(dip_n), .irq_n(irq_n));
  lem_host lem_host_i (.ser(ser), .dout(dout), .dout_oe_n(dout_oe_n), .irq_n(irq_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("counts: %0d compared, %0d mismatched", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bound(input int lim);
    if (k >= lim) begin
      cmp("wait bound", 16'h0, 16'h1);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [4:0] a, input int nb, input logic [15:0] d);
    lem_host_i.xfer({3'b100, a}, nb, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input int nb, input logic [15:0] e);
    lem_host_i.xfer({3'b000, a}, nb, 16'h0, rd);
    cmp(nm, e, rd);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // channel-2 samples every 16 clocks, sign flips every 24 samples
  always begin
    @(negedge clk);
    if (run != 0) begin
      lfsr = nxt(lfsr);
      half = (half + 1) % 24;
      if (half == 0) begin
        amp = -amp;
      end
      x = amp + int'(lfsr[5:0]);
      smp <= '{valid: 1'b1, data: x[19:0]};
      y = y + ((x - y) >>> `LEM_LPF_SHIFT);
      @(negedge clk);
      smp.valid <= 1'b0;
      repeat (14) @(negedge clk);
      lvl = ((y < 0 ? -y : y) >> 11) & 255;
      if (lvl > thr) begin
        above = 1;
        dip = 0;
      end
      if (int'(y >= 0) != zce) begin
        zce = int'(y >= 0);
        cnt = above ? 0 : cnt + 1;
        above = 0;
        if (cnt == cyc && cyc != 0) begin
          dip = 1;
          flags[`LEM_FLAG_DIP] = 1'b1;
        end
      end
      cmp("zero_cross_out", 16'(zce[0]), zc);
      cmp("dip pin", 16'(dip == 0), dip_n);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    smp = '0;
    tcode = 8'h00;
    lfsr = 32'hb61a;
    flags = 8'h00;
    en = 8'h00;
    {run, y, half, thr, cyc, cnt, above, dip, zce} = 0;
    amp = -150000;
    repeat (3) @(negedge clk);
    cmp("dip pin in reset", 16'h0, dip_n);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rdc("timeout reload", `LEM_ADDR_CROSSING_TIMEOUT_RELOAD, 16, `LEM_RST_CROSSING_TIMEOUT_RELOAD);
    rdc("unmapped", 5'h1f, 8, 16'h0);
    wr(`LEM_ADDR_CROSSING_TIMEOUT_RELOAD, 16, 16'h1234);
    rdc("timeout reload", `LEM_ADDR_CROSSING_TIMEOUT_RELOAD, 16, 16'h1234);
    $display("end registers");
    en = 8'h28;
    thr = 16;
    cyc = 2;
    wr(`LEM_ADDR_EVENT_ENABLE_MASK, 8, {8'h00, en});
    wr(`LEM_ADDR_DIPLVL, 8, 16'h10);
    wr(`LEM_ADDR_DIPCYC, 8, 16'd2);
    run = 1;
    repeat (1600) @(negedge clk);
    amp = amp / 4;
    repeat (2400) @(negedge clk);
    cmp("irq on dip", 16'h0, irq_n);
    rdc("status", `LEM_ADDR_STATUS, 8, {8'h00, flags});
    cmp("irq during status read", 16'h1, lem_host_i.irq_mid);
    flags = 8'h00;
    repeat (20) @(negedge clk);
    cmp("irq after read", 16'h1, irq_n);
    amp = amp * 4;
    repeat (1200) @(negedge clk);
    $display("end dip");
    tcode = lfsr[7:0];
    wr(`LEM_ADDR_MODE, 8, 16'h20);
    for (k = 0; k < 2000 && temp_route !== 1'b1; k++) @(negedge clk);
    bound(2000);
    for (k = 0; k < 100 && temp_route === 1'b1; k++) @(negedge clk);
    cmp("conversion cycles", `LEM_TEMP_CYCLES, 16'(k));
    flags[`LEM_FLAG_TEMP] = 1'b1;
    repeat (4) @(negedge clk);
    cmp("irq on conversion", 16'h0, irq_n);
    rdc("thermal", `LEM_ADDR_TEMP, 8, {8'h00, tcode});
    rdc("mode", `LEM_ADDR_MODE, 8, 16'h0);
    rdc("status", `LEM_ADDR_STATUS, 8, {8'h00, flags});
    flags = 8'h00;
    $display("end temperature");
    en = 8'h00;
    wr(`LEM_ADDR_EVENT_ENABLE_MASK, 8, 16'h0);
    wr(`LEM_ADDR_CROSSING_TIMEOUT_RELOAD, 16, 16'd8);
    repeat (800) @(negedge clk);
    z0 = zc;
    for (k = 0; k < 1000 && zc === z0; k++) @(negedge clk);
    bound(1000);
    run = 0;
    for (k = 0; k < 1000 && dip_n === 1'b1; k++) @(negedge clk);
    bound(1000);
    cmp("expiry in window", 16'h1, 16'(k >= 7 * `LEM_TOUT_PRESCALE - 4
      && k <= 8 * `LEM_TOUT_PRESCALE + 8));
    cmp("irq masked", 16'h1, irq_n);
    rdc("status", `LEM_ADDR_STATUS, 8, 16'(1 << `LEM_FLAG_DIP));
    repeat (700) @(negedge clk);
    rdc("status after hold", `LEM_ADDR_STATUS, 8, 16'h0);
    cmp("dip pin held", 16'h0, dip_n);
    wr(`LEM_ADDR_MODE, 8, 16'h10);
    repeat (4) @(negedge clk);
    cmp("dip pin disabled", 16'h1, dip_n);
    $display("end timeout");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
